// ---- hdl/pmtr_pkg.sv ----
// Shared constants and types for the program memory table read block
package pmtr_pkg;
	// Program store shape, larger variant by default
	localparam int ADDR_W_DEF = 11;
	localparam int WORD_W_DEF = 15;
	localparam int EE_AW_DEF = 6;
	localparam int PAGE_BITS = 8;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// Pointer and latch locations in data memory
	localparam logic [7:0] SFR_TBLP = 8'h07;
	localparam logic [7:0] SFR_TABLE_HIGH_BYTE_LATCH = 8'h08;
	localparam logic [7:0] SFR_TBHP = 8'h09;
	localparam logic [7:0] TBLP_RST = 8'h00;
	localparam logic [7:0] TBHP_RST = 8'h00;
	// Serial programming frame: 2 command, 16 address, 16 data bits
	localparam logic [5:0] PGM_HDR_LAST = 6'h11;
	localparam logic [5:0] PGM_DATA_FIRST = 6'h12;
	localparam logic [5:0] PGM_FRAME_LAST = 6'h21;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_FETCH = 3'b001,
		CMD_JUMP = 3'b010,
		CMD_TAB_PTR = 3'b011,
		CMD_TAB_PAGE = 3'b100,
		CMD_TAB_LAST = 3'b101,
		CMD_ALU = 3'b110
	} pmtr_cmd_t;

	typedef enum logic [2:0] {
		ALU_ADD = 3'b000,
		ALU_ADC = 3'b001,
		ALU_SUB = 3'b010,
		ALU_AND = 3'b011,
		ALU_OR = 3'b100,
		ALU_XOR = 3'b101
	} pmtr_alu_t;

	typedef enum logic [1:0] {
		PGM_WR_PROG = 2'b00,
		PGM_RD_PROG = 2'b01,
		PGM_WR_EE = 2'b10,
		PGM_NOP = 2'b11
	} pmtr_pgm_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_TAB = 1'b1
	} pmtr_state_t;
endpackage

// ---- hdl/pmtr_sync.sv ----
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module pmtr_sync (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic rst_val, // Value held during reset
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic meta_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_reg <= rst_val;
			q <= rst_val;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ---- hdl/pmtr_core.sv ----
// Program memory fetch, table read, small ALU and serial programming path
`timescale 1ns/1ps
module pmtr_core #(
	parameter int ADDR_W = pmtr_pkg::ADDR_W_DEF,
	parameter int WORD_W = pmtr_pkg::WORD_W_DEF,
	parameter int EE_AW = pmtr_pkg::EE_AW_DEF
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire pmtr_pkg::pmtr_cmd_t cmd, // Sequencer command
	input wire logic [ADDR_W-1:0] jump_addr, // Jump target
	input wire logic [7:0] operand_addr, // Data register operand
	input wire pmtr_pkg::pmtr_alu_t alu_op, // ALU function
	input wire logic [7:0] alu_a, // ALU first operand
	input wire logic [7:0] alu_b, // ALU second operand
	input wire logic sfr_wr, // Data memory register write
	input wire logic [7:0] sfr_addr, // Data memory register address
	input wire logic [7:0] sfr_wdata, // Data memory write data
	input wire logic external_clear_pin_n, // Clear pin, low holds device
	input wire logic programming_clock_pin, // Serial clock from programmer
	input wire logic programming_data_pin_in, // Serial data pin level
	output logic programming_data_pin_out, // Serial data driven value
	output logic programming_data_pin_oe, // High while driving data pin
	output logic [ADDR_W-1:0] pc_reg, // Program counter
	output logic [WORD_W-1:0] fetch_word_reg, // Fetched instruction
	output logic [ADDR_W-1:0] exec_pc_reg, // Executing instruction address
	output logic stall_reg, // Pipeline stall
	output logic dm_wr_reg, // Data register write pulse
	output logic [7:0] dm_addr_reg, // Data register address
	output logic [7:0] dm_data_reg, // Data register write value
	output logic [7:0] table_high_byte_latch, // Upper table bits
	output logic [7:0] tblp_reg, // Low table pointer
	output logic [7:0] tbhp_reg, // High table pointer
	output logic carry_reg, // Carry or no-borrow flag
	output logic zero_reg, // Zero result flag
	output logic prog_mode_reg, // Programming session active
	output logic ee_wr_reg, // Nonvolatile data write pulse
	output logic [EE_AW-1:0] ee_addr_reg, // Nonvolatile data address
	output logic [7:0] ee_data_reg // Nonvolatile data value
);
	localparam int HI_W = WORD_W - 8;
	logic [WORD_W-1:0] pmem [0:(1<<ADDR_W)-1];
	pmtr_pkg::pmtr_state_t state_reg;
	logic [ADDR_W-1:0] tab_addr_reg;
	logic [7:0] tab_dest_reg;
	logic clr_n_s, pclk_s, pdat_s, pclk_d_reg;
	logic pclk_rise, pclk_fall, run;
	logic [ADDR_W-1:0] tab_addr_next;
	logic [8:0] alu_sum;
	logic [7:0] alu_res;
	logic [WORD_W-1:0] tab_word;

	pmtr_sync u_sync_clr (
		.mclk(mclk), .rst(rst), .rst_val(1'b1),
		.d(external_clear_pin_n), .q(clr_n_s));
	pmtr_sync u_sync_clk (
		.mclk(mclk), .rst(rst), .rst_val(1'b0),
		.d(programming_clock_pin), .q(pclk_s));
	pmtr_sync u_sync_dat (
		.mclk(mclk), .rst(rst), .rst_val(1'b0),
		.d(programming_data_pin_in), .q(pdat_s));

	// Session flag and serial clock history from synchronised pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			prog_mode_reg <= 1'b0;
			pclk_d_reg <= 1'b0;
		end else begin
			prog_mode_reg <= ~clr_n_s;
			pclk_d_reg <= pclk_s;
		end
	end
	assign pclk_rise = pclk_s & ~pclk_d_reg;
	assign pclk_fall = ~pclk_s & pclk_d_reg;
	assign run = ~prog_mode_reg & clr_n_s;

	// Table address selection by read kind
	always_comb begin
		case (cmd)
			pmtr_pkg::CMD_TAB_PTR:
				tab_addr_next = ADDR_W'({tbhp_reg, tblp_reg});
			pmtr_pkg::CMD_TAB_PAGE:
				tab_addr_next = {exec_pc_reg[ADDR_W-1:pmtr_pkg::PAGE_BITS],
					tblp_reg};
			pmtr_pkg::CMD_TAB_LAST:
				tab_addr_next = {{(ADDR_W-pmtr_pkg::PAGE_BITS){1'b1}},
					tblp_reg};
			default:
				tab_addr_next = '0;
		endcase
	end

	// Program counter and fetch
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			pc_reg <= ADDR_W'(pmtr_pkg::RESET_VECTOR);
			exec_pc_reg <= ADDR_W'(pmtr_pkg::RESET_VECTOR);
			fetch_word_reg <= '0;
		end else if (state_reg == pmtr_pkg::ST_IDLE) begin
			if (cmd == pmtr_pkg::CMD_FETCH) begin
				fetch_word_reg <= pmem[pc_reg];
				exec_pc_reg <= pc_reg;
				pc_reg <= pc_reg + 1'b1;
			end else if (cmd == pmtr_pkg::CMD_JUMP) begin
				pc_reg <= jump_addr;
			end
		end
	end

	// Table read sequencing
	assign tab_word = pmem[tab_addr_reg];
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			state_reg <= pmtr_pkg::ST_IDLE;
			stall_reg <= 1'b0;
			tab_addr_reg <= '0;
			tab_dest_reg <= 8'h00;
		end else begin
			case (state_reg)
				pmtr_pkg::ST_IDLE: begin
					if (cmd == pmtr_pkg::CMD_TAB_PTR ||
						cmd == pmtr_pkg::CMD_TAB_PAGE ||
						cmd == pmtr_pkg::CMD_TAB_LAST) begin
						tab_addr_reg <= tab_addr_next;
						tab_dest_reg <= operand_addr;
						stall_reg <= 1'b1;
						state_reg <= pmtr_pkg::ST_TAB;
					end
				end
				pmtr_pkg::ST_TAB: begin
					stall_reg <= 1'b0;
					state_reg <= pmtr_pkg::ST_IDLE;
				end
				default: begin
					stall_reg <= 1'b0;
					state_reg <= pmtr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// High byte latch, written only by a completing table read
	always_ff @(posedge mclk) begin
		if (rst) begin
			table_high_byte_latch <= 8'h00;
		end else if (run && state_reg == pmtr_pkg::ST_TAB) begin
			table_high_byte_latch <= 8'(tab_word[8 +: HI_W]);
		end
	end

	// Table pointers, written from data memory
	always_ff @(posedge mclk) begin
		if (rst) begin
			tblp_reg <= pmtr_pkg::TBLP_RST;
			tbhp_reg <= pmtr_pkg::TBHP_RST;
		end else if (sfr_wr) begin
			if (sfr_addr == pmtr_pkg::SFR_TBLP) begin
				tblp_reg <= sfr_wdata;
			end
			if (sfr_addr == pmtr_pkg::SFR_TBHP) begin
				tbhp_reg <= sfr_wdata;
			end
		end
	end

	// ALU
	always_comb begin
		alu_sum = 9'h000;
		case (alu_op)
			pmtr_pkg::ALU_ADD: alu_sum = {1'b0, alu_a} + {1'b0, alu_b};
			pmtr_pkg::ALU_ADC: alu_sum = {1'b0, alu_a} + {1'b0, alu_b} +
				{8'h00, carry_reg};
			pmtr_pkg::ALU_SUB: alu_sum = {1'b0, alu_a} + {1'b0, ~alu_b} +
				9'h001;
			pmtr_pkg::ALU_AND: alu_sum = {carry_reg, alu_a & alu_b};
			pmtr_pkg::ALU_OR: alu_sum = {carry_reg, alu_a | alu_b};
			pmtr_pkg::ALU_XOR: alu_sum = {carry_reg, alu_a ^ alu_b};
			default: alu_sum = {carry_reg, alu_a};
		endcase
		alu_res = alu_sum[7:0];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			carry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else if (run && state_reg == pmtr_pkg::ST_IDLE &&
			cmd == pmtr_pkg::CMD_ALU) begin
			carry_reg <= alu_sum[8];
			zero_reg <= (alu_res == 8'h00);
		end
	end

	// Data register write port, shared by ALU and table read
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			dm_wr_reg <= 1'b0;
			dm_addr_reg <= 8'h00;
			dm_data_reg <= 8'h00;
		end else if (state_reg == pmtr_pkg::ST_TAB) begin
			dm_wr_reg <= 1'b1;
			dm_addr_reg <= tab_dest_reg;
			dm_data_reg <= tab_word[7:0];
		end else if (cmd == pmtr_pkg::CMD_ALU) begin
			dm_wr_reg <= 1'b1;
			dm_addr_reg <= operand_addr;
			dm_data_reg <= alu_res;
		end else begin
			dm_wr_reg <= 1'b0;
		end
	end

	// Serial programming: shift in on rising clock, drive on falling
	logic [5:0] pbit_reg;
	logic [33:0] pshift_reg;
	logic [15:0] pout_reg;
	logic prd_reg;
	logic [33:0] pframe;
	assign pframe = {pshift_reg[32:0], pdat_s};

	always_ff @(posedge mclk) begin
		if (rst || !prog_mode_reg) begin
			pbit_reg <= 6'h00;
			pshift_reg <= '0;
			pout_reg <= 16'h0000;
			prd_reg <= 1'b0;
			ee_wr_reg <= 1'b0;
			ee_addr_reg <= '0;
			ee_data_reg <= 8'h00;
		end else begin
			ee_wr_reg <= 1'b0;
			if (pclk_rise) begin
				pshift_reg <= pframe;
				pbit_reg <= (pbit_reg == pmtr_pkg::PGM_FRAME_LAST) ?
					6'h00 : pbit_reg + 6'h01;
				if (pbit_reg == pmtr_pkg::PGM_HDR_LAST) begin
					prd_reg <= (pframe[17:16] == pmtr_pkg::PGM_RD_PROG);
					pout_reg <= 16'(pmem[pframe[ADDR_W-1:0]]);
				end
				if (pbit_reg == pmtr_pkg::PGM_FRAME_LAST) begin
					prd_reg <= 1'b0;
					if (pframe[33:32] == pmtr_pkg::PGM_WR_EE) begin
						ee_wr_reg <= 1'b1;
						ee_addr_reg <= pframe[16+EE_AW-1:16];
						ee_data_reg <= pframe[7:0];
					end
				end
			end else if (pclk_fall && prd_reg &&
				pbit_reg >= pmtr_pkg::PGM_DATA_FIRST) begin
				pout_reg <= {pout_reg[14:0], 1'b0};
			end
		end
	end

	// Program store write, only from a completed programming frame
	always_ff @(posedge mclk) begin
		if (prog_mode_reg && !rst && pclk_rise &&
			pbit_reg == pmtr_pkg::PGM_FRAME_LAST &&
			pframe[33:32] == pmtr_pkg::PGM_WR_PROG) begin
			pmem[pframe[16+ADDR_W-1:16]] <= pframe[WORD_W-1:0];
		end
	end

	// Data pin drive during read data bits
	always_ff @(posedge mclk) begin
		if (rst || !prog_mode_reg) begin
			programming_data_pin_oe <= 1'b0;
			programming_data_pin_out <= 1'b0;
		end else if (pclk_fall) begin
			if (prd_reg && pbit_reg >= pmtr_pkg::PGM_DATA_FIRST) begin
				programming_data_pin_oe <= 1'b1;
				programming_data_pin_out <= pout_reg[15];
			end else begin
				programming_data_pin_oe <= 1'b0;
			end
		end
	end
endmodule

// ---- sim/pmtr_monitor.sv ----
// Concurrent checks on the program memory table read block
`timescale 1ns/1ps
module pmtr_monitor #(
	parameter int ADDR_W = 11,
	parameter int WORD_W = 15
) (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire pmtr_pkg::pmtr_cmd_t cmd, // Command
	input wire logic [7:0] operand_addr, // Operand
	input wire logic external_clear_pin_n, // Clear pin
	input wire logic programming_data_pin_oe, // Data enable
	input wire logic [ADDR_W-1:0] pc_reg, // Counter
	input wire logic [ADDR_W-1:0] exec_pc_reg, // Executing
	input wire logic stall_reg, // Stall
	input wire logic dm_wr_reg, // Write pulse
	input wire logic [7:0] dm_addr_reg, // Write address
	input wire logic [7:0] dm_data_reg, // Write data
	input wire logic [7:0] table_high_byte_latch, // Latch
	input wire logic zero_reg, // Zero flag
	input wire logic prog_mode_reg // Session
);
	logic [2:0] hi_cnt_reg;
	logic run;
	logic tab_cmd;
	// Commands count as taken only well after the pin settles high
	always_ff @(posedge mclk) begin
		if (rst || !external_clear_pin_n || prog_mode_reg) begin
			hi_cnt_reg <= 3'h0;
		end else if (hi_cnt_reg != 3'h7) begin
			hi_cnt_reg <= hi_cnt_reg + 3'h1;
		end
	end
	assign run = hi_cnt_reg == 3'h7 && !stall_reg;
	assign tab_cmd = cmd inside {[pmtr_pkg::CMD_TAB_PTR:
		pmtr_pkg::CMD_TAB_LAST]};
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence tab_done;
		stall_reg ##1 (!stall_reg && dm_wr_reg);
	endsequence
	table_steps_a: assert property (
		run && tab_cmd |=> tab_done ##0 dm_addr_reg == $past(operand_addr, 2))
		else $error("Table read timing wrong");
	fetch_step_a: assert property (
		run && cmd == pmtr_pkg::CMD_FETCH |=>
		pc_reg == ADDR_W'($past(pc_reg) + 1'b1) && exec_pc_reg == $past(pc_reg))
		else $error("Fetch address wrong");
	reset_vector_a: assert property (
		$fell(rst) |-> pc_reg == '0 && exec_pc_reg == '0)
		else $error("Counter not zero after reset");
	latch_zero_a: assert property (
		(table_high_byte_latch >> (WORD_W - 8)) == 8'h0)
		else $error("Latch upper bits set");
	latch_hold_a: assert property (
		!$stable(table_high_byte_latch) |-> $past(stall_reg) || $past(rst))
		else $error("Latch changed outside table read");
	alu_write_a: assert property (
		run && cmd == pmtr_pkg::CMD_ALU |=> dm_wr_reg &&
		dm_addr_reg == $past(operand_addr) && zero_reg == (dm_data_reg == 8'h0))
		else $error("ALU result misplaced");
	write_cause_a: assert property (
		dm_wr_reg |-> $past(stall_reg) || $past(cmd) == pmtr_pkg::CMD_ALU)
		else $error("Spurious register write");
	session_halt_a: assert property (
		prog_mode_reg && $past(prog_mode_reg) |-> !dm_wr_reg && pc_reg == '0)
		else $error("Execution during session");
	pin_owner_a: assert property (
		programming_data_pin_oe |-> prog_mode_reg)
		else $error("Data pin driven outside session");
endmodule
bind pmtr_core pmtr_monitor #(.ADDR_W(ADDR_W), .WORD_W(WORD_W))
	u_pmtr_monitor (.*);

// ---- sim/pmtr_prog_model.sv ----
// Serial programmer model for the clear, clock and data pins
`timescale 1ns/1ps
module pmtr_prog_model (
	output logic external_clear_pin_n, // Clear pin
	output logic programming_clock_pin, // Serial clock
	output logic mdl_en, // Model drives data
	output logic mdl_d, // Model data
	input wire logic programming_data_pin_in // Resolved data pin
);
	initial begin
		external_clear_pin_n = 1'b1;
		programming_clock_pin = 1'b0;
		mdl_en = 1'b0;
		mdl_d = 1'b0;
	end
	// One frame; clock stands low between frames
	task automatic frame(input logic [1:0] c, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q);
		logic [33:0] f;
		f = {c, a, d};
		for (int i = 33; i >= 0; i--) begin
			mdl_en = c != 2'b01 || i > 15;
			mdl_d = f[i];
			#80 programming_clock_pin = 1'b1;
			#40 q[i % 16] = programming_data_pin_in;
			#40 programming_clock_pin = 1'b0;
		end
		mdl_en = 1'b0;
	endtask
	task automatic session(input logic on);
		// Offset keeps pin changes off the system clock edge
		#205 external_clear_pin_n = !on;
		#200;
	endtask
endmodule

// ---- sim/program_memory_table_read_tb.sv ----
// Testbench for the program memory table read block
`timescale 1ns/1ps
module program_memory_table_read_tb;
	logic mclk, rst, sfr_wr, flt = 1'b0;
	pmtr_pkg::pmtr_cmd_t cmd;
	pmtr_pkg::pmtr_alu_t alu_op;
	logic [10:0] jump_addr, pc_reg, exec_pc_reg;
	logic [7:0] operand_addr, alu_a, alu_b, sfr_addr, sfr_wdata;
	logic external_clear_pin_n, programming_clock_pin;
	logic programming_data_pin_in, programming_data_pin_out;
	logic programming_data_pin_oe, mdl_en, mdl_d;
	logic [14:0] fetch_word_reg;
	logic stall_reg, dm_wr_reg, carry_reg, zero_reg, prog_mode_reg, ee_wr_reg;
	logic [7:0] dm_addr_reg, dm_data_reg, table_high_byte_latch, tblp_reg;
	logic [7:0] tbhp_reg, ee_data_reg;
	logic [5:0] ee_addr_reg;
	logic [13:0] ee_seen = '0;
	logic [15:0] mem [int];
	logic [15:0] q;
	int num_errors = 0, n_compared = 0;
	int adr[8] = '{0, 1, 2, 'h105, 'h7a5, 'h7ff, 'h3c2, 'h0ff};
	pmtr_core u_pmtr_core (.*);
	pmtr_prog_model u_pmtr_prog_model (.*);
	// Undriven data line toggles so no stale value survives
	assign programming_data_pin_in = programming_data_pin_oe ?
		programming_data_pin_out : mdl_en ? mdl_d : flt;
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) flt <= ~flt;
	always @(posedge mclk) if (ee_wr_reg === 1'b1) ee_seen <= {ee_addr_reg, ee_data_reg};
	task automatic chk(input string n, input logic [15:0] e, g);
		n_compared++;
		if (e !== g) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic final_report;
		$display("Compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic waitpm(logic v);
		for (int w = 0; w < 20 && prog_mode_reg !== v; w++) tick(1);
		#1 chk("mode", v, prog_mode_reg);
		if (prog_mode_reg !== v) final_report();
	endtask
	task automatic go(pmtr_pkg::pmtr_cmd_t c);
		@(posedge mclk);
		cmd <= c;
		@(posedge mclk);
		cmd <= pmtr_pkg::CMD_NONE;
		#1;
	endtask
	task automatic sfr(logic [7:0] a, d);
		@(posedge mclk);
		{sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	task automatic wr(int a);
		mem[a] = 16'($urandom) & 16'h7fff;
		u_pmtr_prog_model.frame(2'b00, 16'(a), mem[a], q);
	endtask
	task automatic tab(pmtr_pkg::pmtr_cmd_t c, int a);
		logic [10:0] p0;
		p0 = pc_reg;
		operand_addr <= 8'(a) ^ 8'h5a;
		@(posedge mclk);
		cmd <= c;
		@(posedge mclk);
		cmd <= pmtr_pkg::CMD_JUMP;
		jump_addr <= ~p0;
		#1 chk("stall", 1'b1, stall_reg);
		@(posedge mclk);
		cmd <= pmtr_pkg::CMD_NONE;
		#1 chk("wr", {1'b1, 1'b0}, {dm_wr_reg, stall_reg});
		chk("addr", 8'(a) ^ 8'h5a, dm_addr_reg);
		chk("low", mem[a][7:0], dm_data_reg);
		chk("high", mem[a][15:8], table_high_byte_latch);
		chk("pc", p0, pc_reg);
	endtask
	initial begin
		logic [7:0] a, b, h;
		logic c;
		logic [8:0] r;
		a = 8'($urandom(32'h99443586));
		rst = 1'b1;
		sfr_wr = 1'b0;
		cmd = pmtr_pkg::CMD_NONE;
		alu_op = pmtr_pkg::ALU_ADD;
		{jump_addr, operand_addr, alu_a, alu_b, sfr_addr, sfr_wdata} = '0;
		tick(5);
		rst <= 1'b0;
		#1 chk("reset_pc", 16'h0000, 16'(pc_reg));
		chk("reset_ptr", 16'h0000, {tbhp_reg, tblp_reg});
		tick(8);
		u_pmtr_prog_model.session(1'b1);
		waitpm(1'b1);
		foreach (adr[i]) wr(adr[i]);
		u_pmtr_prog_model.frame(2'b01, 16'h0105, 16'h0, q);
		chk("rd", mem['h105], q);
		u_pmtr_prog_model.frame(2'b10, 16'h002a, 16'h00c3, q);
		tick(2);
		chk("ee", 14'h2ac3, ee_seen);
		u_pmtr_prog_model.session(1'b0);
		waitpm(1'b0);
		tick(8);
		for (int i = 0; i < 3; i++) begin
			go(pmtr_pkg::CMD_FETCH);
			chk("word", mem[i], fetch_word_reg);
			chk("xpc", 16'(i), exec_pc_reg);
		end
		jump_addr <= 11'h104;
		go(pmtr_pkg::CMD_JUMP);
		go(pmtr_pkg::CMD_FETCH);
		sfr(8'h07, 8'h05);
		tab(pmtr_pkg::CMD_TAB_PAGE, 'h105);
		sfr(8'h07, 8'hff);
		tab(pmtr_pkg::CMD_TAB_LAST, 'h7ff);
		sfr(8'h07, 8'ha5);
		tab(pmtr_pkg::CMD_TAB_LAST, 'h7a5);
		sfr(8'h09, 8'h03);
		sfr(8'h07, 8'hc2);
		tab(pmtr_pkg::CMD_TAB_PTR, 'h3c2);
		h = table_high_byte_latch;
		sfr(pmtr_pkg::SFR_TABLE_HIGH_BYTE_LATCH, ~h);
		tick(1);
		chk("latch", h, table_high_byte_latch);
		sfr(8'h09, 8'h00);
		sfr(8'h07, 8'hff);
		tab(pmtr_pkg::CMD_TAB_PTR, 'h0ff);
		for (int k = 0; k < 7; k++) begin
			a = 8'($urandom);
			b = k == 6 ? a : 8'($urandom);
			c = carry_reg;
			{alu_a, alu_b, operand_addr} <= {a, b, 8'h50};
			alu_op <= pmtr_pkg::pmtr_alu_t'(3'(k < 6 ? k : 5));
			case (k)
				0: r = a + b;
				1: r = a + b + c;
				2: r = a + {1'b0, ~b} + 9'h1;
				3: r = {c, a & b};
				4: r = {c, a | b};
				default: r = {c, a ^ b};
			endcase
			go(pmtr_pkg::CMD_ALU);
			chk("alu", {r, r[7:0] == 8'h0}, {carry_reg, dm_data_reg, zero_reg});
		end
		final_report();
	end
endmodule
